// ---- twm_pkg.sv ----
package twm_pkg;

  localparam logic [6:0] GC_ADDR        = 7'h00;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
  localparam logic [7:0] HALF_CYC_DEF   = 8'h0A;
  localparam logic [3:0] ACK_BIT        = 4'h8;
  localparam logic       TRANSMIT_READY_FLAG_RST      = 1'b1;
  localparam logic       TRANSMISSION_COMPLETE_FLAG_RST     = 1'b1;
  localparam logic       LINE_RST       = 1'b1;

  typedef enum logic [6:0] {
    L_IDLE  = 7'h01,
    M_START = 7'h02,
    M_BIT   = 7'h04,
    M_STOP  = 7'h08,
    S_ADDR  = 7'h10,
    S_DATA  = 7'h20,
    S_WAIT  = 7'h40
  } twm_lst_t;

  typedef struct packed {
    logic master_en;
    logic slave_en;
    logic start_seq;
    logic thr_seq;
    logic rd_seq;
  } twm_s2l_t;

  typedef struct packed {
    logic [6:0]  own_addr;
    logic [6:0]  dev_addr;
    logic [1:0]  internal_address_register_size;
    logic [23:0] internal_address_register;
  } twm_cfg_t;

  typedef struct packed {
    logic idle;
    logic slave_access_flag;
    logic rdir;
    logic clock_wait_state_flag;
    logic rx_seq;
    logic txdone_t;
    logic nack_t;
    logic arb_t;
    logic eos_t;
    logic general_call_access_flag_t;
  } twm_l2s_t;

endpackage : twm_pkg

// ---- twm_sync.sv ----
`timescale 1ns/1ps
module twm_sync #(
  parameter int         WIDTH = 1,
  parameter logic       INIT  = 1'b0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  if (WIDTH < 1) begin : g_bad_width
    $error("twm_sync: WIDTH must be at least 1");
  end

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {WIDTH{INIT}};
      q      <= {WIDTH{INIT}};
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : twm_sync

// ---- twm_cond.sv ----
`timescale 1ns/1ps
module twm_cond
  import twm_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det,
  output logic      busy
);
  logic scl_d_r;
  logic sda_d_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_r <= LINE_RST;
      sda_d_r <= LINE_RST;
    end else begin
      scl_d_r <= scl;
      sda_d_r <= sda;
    end
  end

  assign scl_rise  = scl & ~scl_d_r;
  assign scl_fall  = ~scl & scl_d_r;
  assign start_det = scl & scl_d_r & sda_d_r & ~sda;
  assign stop_det  = scl & scl_d_r & ~sda_d_r & sda;

  // bus busy from any start until the next stop, whoever drives them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else if (start_det) begin
      busy <= 1'b1;
    end else if (stop_det) begin
      busy <= 1'b0;
    end
  end
endmodule : twm_cond

// ---- twm_top.sv ----
`timescale 1ns/1ps
module twm_top
  import twm_pkg::*;
#(
  parameter logic [7:0] HALF_CYC = HALF_CYC_DEF
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        LINK_CLK,
  input  wire logic        SW_RESET,
  input  wire logic        MASTER_ENABLE_CMD,
  input  wire logic        MASTER_DISABLE_CMD,
  input  wire logic        SLAVE_ENABLE_CMD,
  input  wire logic        SLAVE_DISABLE_CMD,
  input  wire logic        START_CMD,
  input  wire logic [6:0]  OWN_SLAVE_ADDRESS,
  input  wire logic [6:0]  TARGET_DEVICE_ADDRESS,
  input  wire logic [1:0]  INTERNAL_ADDRESS_SIZE,
  input  wire logic [23:0] INTERNAL_ADDRESS_REGISTER,
  input  wire logic        TRANSMIT_HOLDING_WRITE,
  input  wire logic [7:0]  TRANSMIT_HOLDING_REGISTER,
  input  wire logic        RECEIVE_HOLDING_READ,
  output logic      [7:0]  RECEIVE_HOLDING_REGISTER,
  input  wire logic        STATUS_READ,
  output logic             TRANSMISSION_COMPLETE_FLAG,
  output logic             TRANSMIT_READY_FLAG,
  output logic             RECEIVE_READY_FLAG,
  output logic             NACK_FLAG,
  output logic             ARBITRATION_LOST_FLAG,
  output logic             SLAVE_ACCESS_FLAG,
  output logic             SLAVE_READ_DIRECTION,
  output logic             END_OF_SLAVE_ACCESS_FLAG,
  output logic             CLOCK_WAIT_STATE_FLAG,
  output logic             GENERAL_CALL_ACCESS_FLAG,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE,
  input  wire logic        SCL_IN,
  output logic             SCL_OUT,
  output logic             SCL_OE
);

  if (HALF_CYC < 8'h02) begin : g_bad_half
    $error("twm_top: HALF_CYC must be at least 2");
  end

  // ---------------- system clock side ----------------
  logic       master_en_r, slave_en_r, start_seq_r, thr_seq_r, rd_seq_r, rx_prev_r;
  logic [7:0] thr_r, rx_data_r;
  twm_s2l_t   s2l, s2l_s;
  twm_cfg_t   cfg, cfg_s;
  twm_l2s_t   l2s, l2s_s, l2s_p;
  logic       ev_rx, ev_tx, ev_nack, ev_arb, ev_eos, ev_general_call_access_flag;

  // enables move only on commands and SW_RESET, never on arbitration loss
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      master_en_r <= 1'b0;
      slave_en_r  <= 1'b0;
    end else if (SW_RESET) begin
      master_en_r <= 1'b0;
      slave_en_r  <= 1'b0;
    end else begin
      master_en_r <= MASTER_DISABLE_CMD ? 1'b0 : (MASTER_ENABLE_CMD | master_en_r);
      slave_en_r  <= SLAVE_DISABLE_CMD ? 1'b0 : (SLAVE_ENABLE_CMD | slave_en_r);
    end
  end

  // sequence bits are never cleared by SW_RESET so both domains stay in step
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      start_seq_r <= 1'b0;
      thr_seq_r   <= 1'b0;
      thr_r       <= 8'h00;
    end else begin
      start_seq_r <= start_seq_r ^ START_CMD;
      thr_seq_r   <= thr_seq_r ^ TRANSMIT_HOLDING_WRITE;
      if (TRANSMIT_HOLDING_WRITE) begin
        thr_r <= TRANSMIT_HOLDING_REGISTER;
      end
    end
  end

  assign s2l = '{master_en: master_en_r, slave_en: slave_en_r, start_seq: start_seq_r,
                 thr_seq: thr_seq_r, rd_seq: rd_seq_r};
  assign cfg = '{own_addr: OWN_SLAVE_ADDRESS, dev_addr: TARGET_DEVICE_ADDRESS,
                 internal_address_register_size: INTERNAL_ADDRESS_SIZE, internal_address_register: INTERNAL_ADDRESS_REGISTER};

  twm_sync #(.WIDTH($bits(twm_l2s_t)), .INIT(1'b0)) u_l2s (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .d     (l2s),
    .q     (l2s_s)
  );

  assign ev_rx   = l2s_s.rx_seq ^ l2s_p.rx_seq;
  assign ev_tx   = l2s_s.txdone_t ^ l2s_p.txdone_t;
  assign ev_nack = l2s_s.nack_t ^ l2s_p.nack_t;
  assign ev_arb  = l2s_s.arb_t ^ l2s_p.arb_t;
  assign ev_eos  = l2s_s.eos_t ^ l2s_p.eos_t;
  assign ev_general_call_access_flag = l2s_s.general_call_access_flag_t ^ l2s_p.general_call_access_flag_t;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      l2s_p                    <= '0;
      rx_prev_r                <= 1'b0;
      rd_seq_r                 <= 1'b0;
      RECEIVE_HOLDING_REGISTER <= 8'h00;
    end else begin
      l2s_p <= l2s_s;
      if (ev_rx) begin
        RECEIVE_HOLDING_REGISTER <= rx_data_r;
        rx_prev_r                <= l2s_s.rx_seq;
      end
      if (RECEIVE_HOLDING_READ) begin
        rd_seq_r <= rx_prev_r;
      end
    end
  end

  // sticky flags: an event in the clearing cycle wins
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      TRANSMIT_READY_FLAG      <= TRANSMIT_READY_FLAG_RST;
      RECEIVE_READY_FLAG       <= 1'b0;
      NACK_FLAG                <= 1'b0;
      ARBITRATION_LOST_FLAG    <= 1'b0;
      END_OF_SLAVE_ACCESS_FLAG <= 1'b0;
      GENERAL_CALL_ACCESS_FLAG <= 1'b0;
    end else if (SW_RESET) begin
      TRANSMIT_READY_FLAG      <= TRANSMIT_READY_FLAG_RST;
      RECEIVE_READY_FLAG       <= 1'b0;
      NACK_FLAG                <= 1'b0;
      ARBITRATION_LOST_FLAG    <= 1'b0;
      END_OF_SLAVE_ACCESS_FLAG <= 1'b0;
      GENERAL_CALL_ACCESS_FLAG <= 1'b0;
    end else begin
      TRANSMIT_READY_FLAG      <= ev_tx | (TRANSMIT_READY_FLAG & ~TRANSMIT_HOLDING_WRITE);
      RECEIVE_READY_FLAG       <= ev_rx | (RECEIVE_READY_FLAG & ~RECEIVE_HOLDING_READ);
      NACK_FLAG                <= ev_nack | (NACK_FLAG & ~STATUS_READ);
      ARBITRATION_LOST_FLAG    <= ev_arb | (ARBITRATION_LOST_FLAG & ~STATUS_READ);
      END_OF_SLAVE_ACCESS_FLAG <= ev_eos | (END_OF_SLAVE_ACCESS_FLAG & ~STATUS_READ);
      GENERAL_CALL_ACCESS_FLAG <= ev_general_call_access_flag | (GENERAL_CALL_ACCESS_FLAG & ~STATUS_READ);
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      TRANSMISSION_COMPLETE_FLAG <= TRANSMISSION_COMPLETE_FLAG_RST;
      SLAVE_ACCESS_FLAG          <= 1'b0;
      SLAVE_READ_DIRECTION       <= 1'b0;
      CLOCK_WAIT_STATE_FLAG      <= 1'b0;
    end else begin
      TRANSMISSION_COMPLETE_FLAG <= l2s_s.idle;
      SLAVE_ACCESS_FLAG          <= l2s_s.slave_access_flag;
      SLAVE_READ_DIRECTION       <= l2s_s.rdir;
      CLOCK_WAIT_STATE_FLAG      <= l2s_s.clock_wait_state_flag;
    end
  end

  // ---------------- link clock side ----------------
  logic [1:0] lrst_r;
  logic       lrst_n;
  logic       scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det, busy;
  twm_lst_t   st_r;
  logic [7:0] sh_r, tmr_r, internal_address_register_byte;
  logic [3:0] cnt_r;
  logic [1:0] idx_r;
  logic       ph_r, dbyte_r, ackph_r, stretch_r, taken_r, start_tk_r, arb_blk_r;
  logic       slave_access_flag_r, acc_r, rdir_r, idle_r, rx_seq_r;
  logic       txdone_t_r, nack_t_r, arb_t_r, eos_t_r, general_call_access_flag_t_r;
  logic       tick, thr_avail, rhr_full, start_pend, gc_hit, own_hit;

  // reset released in step with the link clock
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lrst_r <= 2'b00;
    end else begin
      lrst_r <= {lrst_r[0], 1'b1};
    end
  end
  assign lrst_n = lrst_r[1];

  twm_sync #(.WIDTH(2), .INIT(LINE_RST)) u_pins (
    .clk   (LINK_CLK),
    .rst_n (lrst_n),
    .d     ({SCL_IN, SDA_IN}),
    .q     ({scl_s, sda_s})
  );

  twm_sync #(.WIDTH($bits(twm_s2l_t)), .INIT(1'b0)) u_s2l (
    .clk   (LINK_CLK),
    .rst_n (lrst_n),
    .d     (s2l),
    .q     (s2l_s)
  );

  // configuration is quasi-static: software changes it only while idle
  twm_sync #(.WIDTH($bits(twm_cfg_t)), .INIT(1'b0)) u_cfg (
    .clk   (LINK_CLK),
    .rst_n (lrst_n),
    .d     (cfg),
    .q     (cfg_s)
  );

  twm_cond u_cond (
    .clk       (LINK_CLK),
    .rst_n     (lrst_n),
    .scl       (scl_s),
    .sda       (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det),
    .busy      (busy)
  );

  assign tick       = (tmr_r == HALF_CYC - 8'h01);
  assign thr_avail  = s2l_s.thr_seq != taken_r;
  assign rhr_full   = s2l_s.rd_seq != rx_seq_r;
  assign start_pend = s2l_s.start_seq != start_tk_r;
  assign gc_hit     = (sh_r[7:1] == GC_ADDR) & ~sh_r[0];
  assign own_hit    = (sh_r[7:1] == cfg_s.own_addr) & (sh_r[7:1] != GC_ADDR);

  always_comb begin
    case (idx_r)
      2'h3:    internal_address_register_byte = cfg_s.internal_address_register[23:16];
      2'h2:    internal_address_register_byte = cfg_s.internal_address_register[15:8];
      default: internal_address_register_byte = cfg_s.internal_address_register[7:0];
    endcase
  end

  // thr_r is read here only after its sequence bit has crossed, so it is stable
  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      st_r <= L_IDLE;
      {sh_r, tmr_r, rx_data_r} <= '0;
      {cnt_r, idx_r, ph_r, dbyte_r, ackph_r, stretch_r, taken_r, start_tk_r} <= '0;
      {arb_blk_r, slave_access_flag_r, acc_r, rdir_r, rx_seq_r, SDA_OE, SCL_OE} <= '0;
      {txdone_t_r, nack_t_r, arb_t_r, eos_t_r, general_call_access_flag_t_r} <= '0;
    end else begin
      if (stop_det) begin
        arb_blk_r <= 1'b0;
      end
      case (st_r)
        L_IDLE: begin
          {SDA_OE, SCL_OE, stretch_r} <= 3'b000;
          tmr_r <= 8'h00;
          if (start_det && s2l_s.slave_en) begin
            st_r    <= S_ADDR;
            cnt_r   <= 4'h0;
            ackph_r <= 1'b0;
          end else if (s2l_s.master_en && start_pend && !busy) begin
            st_r       <= M_START;
            start_tk_r <= s2l_s.start_seq;
            SDA_OE     <= 1'b1;
          end
        end
        M_START: begin
          tmr_r <= tmr_r + 8'h01;
          if (tick) begin
            {SCL_OE, ph_r, dbyte_r} <= 3'b100;
            sh_r  <= {cfg_s.dev_addr, 1'b0};
            idx_r <= cfg_s.internal_address_register_size;
            cnt_r <= 4'h0;
            tmr_r <= 8'h00;
            st_r  <= M_BIT;
          end
        end
        M_BIT: begin
          if (!ph_r) begin
            SDA_OE <= (cnt_r < ACK_BIT) ? ~sh_r[7] : 1'b0;
            tmr_r  <= tmr_r + 8'h01;
            if (tick) begin
              {SCL_OE, ph_r} <= 2'b01;
              tmr_r          <= 8'h00;
            end
          // high time counts from the line going high, so slaves may stretch
          end else if (scl_s) begin
            tmr_r <= tmr_r + 8'h01;
            if ((cnt_r < ACK_BIT) && sh_r[7] && !sda_s) begin
              st_r      <= L_IDLE;
              arb_t_r   <= ~arb_t_r;
              arb_blk_r <= 1'b1;
              {SDA_OE, SCL_OE} <= 2'b00;
            end else if (tick) begin
              {SCL_OE, ph_r} <= 2'b10;
              tmr_r          <= 8'h00;
              if (cnt_r < ACK_BIT) begin
                sh_r  <= {sh_r[6:0], 1'b0};
                cnt_r <= cnt_r + 4'h1;
              end else begin
                txdone_t_r <= txdone_t_r ^ dbyte_r;
                cnt_r      <= 4'h0;
                if (sda_s) begin
                  nack_t_r <= ~nack_t_r;
                  st_r     <= M_STOP;
                end else if (idx_r != 2'h0) begin
                  sh_r    <= internal_address_register_byte;
                  idx_r   <= idx_r - 2'h1;
                  dbyte_r <= 1'b0;
                end else if (thr_avail) begin
                  sh_r    <= thr_r;
                  taken_r <= s2l_s.thr_seq;
                  dbyte_r <= 1'b1;
                end else begin
                  st_r <= M_STOP;
                end
              end
            end
          end
        end
        M_STOP: begin
          if (!ph_r) begin
            SDA_OE <= 1'b1;
            tmr_r  <= tmr_r + 8'h01;
            if (tick) begin
              {SCL_OE, ph_r} <= 2'b01;
              tmr_r          <= 8'h00;
            end
          end else if (scl_s) begin
            tmr_r <= tmr_r + 8'h01;
            if (tick) begin
              SDA_OE <= 1'b0;
              tmr_r  <= 8'h00;
              st_r   <= L_IDLE;
            end
          end
        end
        S_ADDR, S_DATA, S_WAIT: begin
          if (stop_det || start_det) begin
            eos_t_r <= eos_t_r ^ slave_access_flag_r;
            {slave_access_flag_r, SDA_OE, SCL_OE, stretch_r, ackph_r} <= 5'b00000;
            cnt_r <= 4'h0;
            acc_r <= acc_r & start_det;
            st_r  <= start_det ? S_ADDR : L_IDLE;
          end else if (scl_rise && (cnt_r < ACK_BIT) && (st_r != S_WAIT)) begin
            sh_r  <= {sh_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end else if (st_r == S_ADDR) begin
            if (scl_fall && (cnt_r == ACK_BIT)) begin
              if ((own_hit || gc_hit) && !arb_blk_r && s2l_s.slave_en) begin
                {SDA_OE, slave_access_flag_r, acc_r, ackph_r} <= 4'b1111;
                rdir_r   <= sh_r[0];
                general_call_access_flag_t_r <= general_call_access_flag_t_r ^ gc_hit;
                st_r     <= S_DATA;
              end else begin
                acc_r <= 1'b0;
                st_r  <= S_WAIT;
              end
            end
          end else if (st_r == S_DATA) begin
            if (scl_rise && rdir_r && !ackph_r) begin
              txdone_t_r <= ~txdone_t_r;
              if (sda_s) begin
                nack_t_r <= ~nack_t_r;
                st_r     <= S_WAIT;
              end else begin
                ackph_r <= 1'b1;
              end
            // drives change only while the clock is low, never as start or stop
            end else if ((scl_fall || stretch_r) && (cnt_r == ACK_BIT)) begin
              if (rdir_r && ackph_r) begin
                if (thr_avail) begin
                  sh_r    <= thr_r;
                  taken_r <= s2l_s.thr_seq;
                  SDA_OE  <= ~thr_r[7];
                  cnt_r   <= 4'h0;
                  {ackph_r, SCL_OE, stretch_r} <= 3'b000;
                end else begin
                  {SDA_OE, SCL_OE, stretch_r} <= 3'b011;
                end
              end else if (rdir_r) begin
                SDA_OE <= 1'b0;
              end else if (ackph_r) begin
                {SDA_OE, ackph_r} <= 2'b00;
                cnt_r <= 4'h0;
              end else if (rhr_full) begin
                {SCL_OE, stretch_r} <= 2'b11;
              end else begin
                rx_data_r <= sh_r;
                rx_seq_r  <= ~rx_seq_r;
                {SDA_OE, ackph_r, SCL_OE, stretch_r} <= 4'b1100;
              end
            end else if (scl_fall && rdir_r && !ackph_r) begin
              SDA_OE <= ~sh_r[7];
            end
          end
        end
        default: begin
          st_r <= L_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      idle_r <= TRANSMISSION_COMPLETE_FLAG_RST;
    end else begin
      idle_r <= !acc_r && (st_r != M_START) && (st_r != M_BIT) && (st_r != M_STOP);
    end
  end

  assign l2s = '{idle: idle_r, slave_access_flag: slave_access_flag_r, rdir: rdir_r, clock_wait_state_flag: stretch_r,
                 rx_seq: rx_seq_r, txdone_t: txdone_t_r, nack_t: nack_t_r,
                 arb_t: arb_t_r, eos_t: eos_t_r, general_call_access_flag_t: general_call_access_flag_t_r};

  // open-drain: only ever pull low
  assign SDA_OUT = 1'b0;
  assign SCL_OUT = 1'b0;

endmodule : twm_top

// ---- twm_properties.sv ----
`timescale 1ns/1ps
module twm_properties (
  input wire logic       SYS_CLK,
  input wire logic       RST_N,
  input wire logic       SW_RESET,
  input wire logic       STATUS_READ,
  input wire logic       TRANSMIT_HOLDING_WRITE,
  input wire logic       RECEIVE_HOLDING_READ,
  input wire logic [7:0] RECEIVE_HOLDING_REGISTER,
  input wire logic       TRANSMISSION_COMPLETE_FLAG,
  input wire logic       TRANSMIT_READY_FLAG,
  input wire logic       RECEIVE_READY_FLAG,
  input wire logic       NACK_FLAG,
  input wire logic       ARBITRATION_LOST_FLAG,
  input wire logic       SLAVE_ACCESS_FLAG,
  input wire logic       END_OF_SLAVE_ACCESS_FLAG,
  input wire logic       CLOCK_WAIT_STATE_FLAG,
  input wire logic       GENERAL_CALL_ACCESS_FLAG,
  input wire logic       SCL_OE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // the nack, lost and general call flags may only drop on a status read or a soft reset
  wire logic keep = !STATUS_READ && !SW_RESET;
  sequence s_access_end;
    $fell(SLAVE_ACCESS_FLAG) && !$past(SW_RESET);
  endsequence
  sequence s_closed;
    ##[0:2] (END_OF_SLAVE_ACCESS_FLAG && TRANSMISSION_COMPLETE_FLAG);
  endsequence
  property p_end; s_access_end |-> s_closed; endproperty
  property p_transmit_ready_flag; TRANSMIT_HOLDING_WRITE |=> !TRANSMIT_READY_FLAG; endproperty
  property p_receive_ready_flag; RECEIVE_HOLDING_READ |=> !RECEIVE_READY_FLAG; endproperty
  property p_rhr; RECEIVE_READY_FLAG && !RECEIVE_HOLDING_READ
    |=> $stable(RECEIVE_HOLDING_REGISTER); endproperty
  property p_arb; ARBITRATION_LOST_FLAG && keep |=> ARBITRATION_LOST_FLAG; endproperty
  property p_nack; NACK_FLAG && keep |=> NACK_FLAG; endproperty
  property p_gc; GENERAL_CALL_ACCESS_FLAG && keep |=> GENERAL_CALL_ACCESS_FLAG; endproperty
  // the flag lags the pin by the crossing, so the pin is still held when it rises
  property p_wait; $rose(CLOCK_WAIT_STATE_FLAG) |-> SCL_OE; endproperty
  a_end: assert property (p_end) else $error("access end not flagged");
  a_transmit_ready_flag: assert property (p_transmit_ready_flag) else $error("ready kept after write");
  a_receive_ready_flag: assert property (p_receive_ready_flag) else $error("receive ready kept after read");
  a_rhr: assert property (p_rhr) else $error("held byte overwritten");
  a_arb: assert property (p_arb) else $error("lost flag dropped");
  a_nack: assert property (p_nack) else $error("nack flag dropped");
  a_gc: assert property (p_gc) else $error("general call flag dropped");
  a_wait: assert property (p_wait) else $error("wait shown without stretch");
endmodule : twm_properties
bind twm_top twm_properties u_props (.*);

// ---- twm_bus_model.sv ----
`timescale 1ns/1ps
module twm_bus_model (
  input  wire logic sda,
  input  wire logic scl,
  output logic      sda_oe,
  output logic      scl_oe
);
  localparam int Q = 600;
  initial begin
    sda_oe = 1'b0;
    scl_oe = 1'b0;
  end
  task automatic hold(input logic v);
    sda_oe = v;
  endtask : hold
  // waits on the line, not our own drive, so a stretching slave is honoured
  task automatic put(input logic b, output logic r);
    scl_oe = 1'b1;
    #Q sda_oe = ~b;
    #Q scl_oe = 1'b0;
    wait (scl === 1'b1);
    #Q r = sda;
    #Q scl_oe = 1'b1;
  endtask : put
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
                      output logic a);
    for (int i = 7; i >= 0; i--) put(d[i], q[i]);
    put(ak, a);
  endtask : xfer
  task automatic start;
    sda_oe = 1'b0;
    #Q scl_oe = 1'b0;
    wait (scl === 1'b1);
    #Q sda_oe = 1'b1;
    #Q scl_oe = 1'b1;
  endtask : start
  task automatic stop;
    sda_oe = 1'b1;
    #Q scl_oe = 1'b0;
    wait (scl === 1'b1);
    #Q sda_oe = 1'b0;
    #Q;
  endtask : stop
  // plays an addressed receiver on the device's clock and acks every byte
  task automatic take(output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      @(posedge scl) q[i] = sda;
    end
    @(negedge scl) sda_oe = 1'b1;
    @(negedge scl) sda_oe = 1'b0;
  endtask : take
endmodule : twm_bus_model

// ---- twm_top_tb.sv ----
`timescale 1ns/1ps
module twm_top_tb;
  import twm_pkg::*;
  logic        SYS_CLK = 1'b0;
  logic        LINK_CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic [6:0]  OWN_SLAVE_ADDRESS = 7'h00;
  logic [6:0]  TARGET_DEVICE_ADDRESS = 7'h00;
  logic [1:0]  INTERNAL_ADDRESS_SIZE = 2'h0;
  logic [23:0] INTERNAL_ADDRESS_REGISTER = 24'h000000;
  logic [7:0]  TRANSMIT_HOLDING_REGISTER = 8'h00;
  logic [7:0]  RECEIVE_HOLDING_REGISTER;
  logic        TRANSMISSION_COMPLETE_FLAG, TRANSMIT_READY_FLAG, RECEIVE_READY_FLAG, NACK_FLAG;
  logic        ARBITRATION_LOST_FLAG, SLAVE_ACCESS_FLAG, SLAVE_READ_DIRECTION;
  logic        END_OF_SLAVE_ACCESS_FLAG, CLOCK_WAIT_STATE_FLAG, GENERAL_CALL_ACCESS_FLAG;
  logic        SDA_OUT, SCL_OUT, SDA_OE, SCL_OE, bm_sda, bm_scl, a, prev_rx = 1'b0;
  logic [8:0]  pul = 9'h000;
  logic [7:0]  q;
  logic [31:0] rnd = 32'hBD0B;
  logic [7:0]  exp_q[$];
  int          error_cnt = 0, checked = 0, cyc = 0;
  wire         sda = ~(SDA_OE | bm_sda);
  wire         scl = ~(SCL_OE | bm_scl);
  always #50 SYS_CLK = ~SYS_CLK;
  always #24 LINK_CLK = ~LINK_CLK;
  twm_top #(.HALF_CYC(8'h04)) dut (.*, .SW_RESET(pul[0]), .MASTER_ENABLE_CMD(pul[1]),
    .MASTER_DISABLE_CMD(pul[2]), .SLAVE_ENABLE_CMD(pul[3]), .SLAVE_DISABLE_CMD(pul[4]),
    .START_CMD(pul[5]), .TRANSMIT_HOLDING_WRITE(pul[6]), .RECEIVE_HOLDING_READ(pul[7]),
    .STATUS_READ(pul[8]), .SDA_IN(sda), .SCL_IN(scl));
  twm_bus_model bm (.sda(sda), .scl(scl), .sda_oe(bm_sda), .scl_oe(bm_scl));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic fire(input int i);
    @(posedge SYS_CLK) pul <= 9'h001 << i;
    @(posedge SYS_CLK) pul <= 9'h000;
  endtask : fire
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  // every fresh receive-ready takes the oldest expected byte
  always @(posedge SYS_CLK) begin
    prev_rx <= RECEIVE_READY_FLAG;
    if (RECEIVE_READY_FLAG === 1'b1 && prev_rx !== 1'b1) begin
      if (exp_q.size() > 0) chk(RECEIVE_HOLDING_REGISTER, exp_q.pop_front());
      else chk(8'h00, 8'hFF);
    end
  end
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    repeat (10) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    repeat (32) rnd = lfsr(rnd);
    @(posedge SYS_CLK) OWN_SLAVE_ADDRESS <= {2'b01, rnd[4:0]};
    TARGET_DEVICE_ADDRESS <= {1'b1, rnd[10:5]};
    fire(0);
    fire(2);
    fire(3);
    repeat (8) @(posedge SYS_CLK);
    fork
      begin
        bm.start();
        bm.xfer({OWN_SLAVE_ADDRESS, 1'b0}, 1'b1, q, a);
        chk(a, 1'b0);
        exp_q.push_back(rnd[15:8]);
        bm.xfer(rnd[15:8], 1'b1, q, a);
        exp_q.push_back(rnd[23:16]);
        bm.xfer(rnd[23:16], 1'b1, q, a);
        bm.stop();
      end
      begin
        wait (CLOCK_WAIT_STATE_FLAG === 1'b1);
        chk(SLAVE_ACCESS_FLAG, 1'b1);
        chk(SLAVE_READ_DIRECTION, 1'b0);
        chk(TRANSMISSION_COMPLETE_FLAG, 1'b0);
        fire(7);
        repeat (3) @(posedge SYS_CLK);
        wait (RECEIVE_READY_FLAG === 1'b1);
        fire(7);
      end
    join
    repeat (20) @(posedge SYS_CLK);
    chk(END_OF_SLAVE_ACCESS_FLAG, 1'b1);
    chk({SLAVE_ACCESS_FLAG, TRANSMISSION_COMPLETE_FLAG}, 2'b01);
    fire(8);
    $display("slave write test done");
    repeat (32) rnd = lfsr(rnd);
    fork
      begin
        bm.start();
        bm.xfer({OWN_SLAVE_ADDRESS, 1'b1}, 1'b1, q, a);
        bm.xfer(8'hFF, 1'b0, q, a);
        chk(q, rnd[7:0]);
        bm.xfer(8'hFF, 1'b1, q, a);
        chk(q, rnd[15:8]);
        bm.stop();
      end
      begin
        wait (CLOCK_WAIT_STATE_FLAG === 1'b1);
        chk(SLAVE_READ_DIRECTION, 1'b1);
        @(posedge SYS_CLK) TRANSMIT_HOLDING_REGISTER <= rnd[7:0];
        fire(6);
        repeat (2) @(posedge SYS_CLK);
        chk(TRANSMIT_READY_FLAG, 1'b0);
        wait (TRANSMIT_READY_FLAG === 1'b1);
        @(posedge SYS_CLK) TRANSMIT_HOLDING_REGISTER <= rnd[15:8];
        fire(6);
      end
    join
    repeat (20) @(posedge SYS_CLK);
    chk({NACK_FLAG, TRANSMISSION_COMPLETE_FLAG, SLAVE_ACCESS_FLAG}, 3'b110);
    fire(8);
    $display("slave read test done");
    bm.start();
    bm.xfer(8'h00, 1'b1, q, a);
    chk(a, 1'b0);
    exp_q.push_back(rnd[23:16]);
    bm.xfer(rnd[23:16], 1'b1, q, a);
    bm.stop();
    chk(GENERAL_CALL_ACCESS_FLAG, 1'b1);
    fire(7);
    fire(8);
    $display("general call test done");
    repeat (32) rnd = lfsr(rnd);
    wait (TRANSMISSION_COMPLETE_FLAG === 1'b1);
    fire(4);
    fire(1);
    @(posedge SYS_CLK) TRANSMIT_HOLDING_REGISTER <= rnd[31:24];
    TARGET_DEVICE_ADDRESS <= {TEN_BIT_PREFIX, rnd[1:0]};
    INTERNAL_ADDRESS_SIZE <= 2'h1;
    INTERNAL_ADDRESS_REGISTER <= {rnd[27:12], rnd[9:2]};
    fire(6);
    fire(5);
    bm.take(q);
    chk(q, {TEN_BIT_PREFIX, rnd[1:0], 1'b0});
    bm.take(q);
    chk(q, rnd[9:2]);
    bm.take(q);
    chk(q, rnd[31:24]);
    repeat (20) @(posedge SYS_CLK);
    chk({TRANSMIT_READY_FLAG, TRANSMISSION_COMPLETE_FLAG, NACK_FLAG}, 3'b110);
    $display("master write test done");
    @(posedge SYS_CLK) TRANSMIT_HOLDING_REGISTER <= rnd[23:16];
    fire(6);
    bm.start();
    fire(5);
    repeat (100) @(posedge SYS_CLK);
    chk({SDA_OE, SCL_OE}, 2'b00);
    bm.stop();
    wait (SDA_OE === 1'b1);
    bm.hold(1'b1);
    wait (ARBITRATION_LOST_FLAG === 1'b1);
    repeat (4) @(posedge SYS_CLK);
    chk({SDA_OE, SCL_OE, SLAVE_ACCESS_FLAG}, 3'b000);
    chk({SDA_OUT, SCL_OUT, CLOCK_WAIT_STATE_FLAG}, 3'b000);
    bm.hold(1'b0);
    chk(exp_q.size(), 8'h00);
    $display("arbitration test done");
    wrap_up();
  end
endmodule : twm_top_tb
